// *** rtl/rssx_pkg.sv ***
package rssx_pkg;
  // Register byte offsets on the APB window
  localparam logic [11:0] OFF_CMD    = 12'h000;
  localparam logic [11:0] OFF_ACC    = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_WDT    = 12'h00C;
  localparam logic [11:0] OFF_CTRL   = 12'h010;
  localparam logic [11:0] OFF_FILE   = 12'h200;
  localparam logic [11:0] FILE_SPAN  = 12'h200;

  // Command word fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_DEST_BIT = 3;
  localparam int CMD_FA_LSB   = 4;
  localparam int CMD_LIT_LSB  = 16;

  // Status bit positions
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;

  // Control bit positions
  localparam int CTRL_WDT_EN = 0;

  // Reset and clear values
  localparam logic [7:0] ACC_RST    = 8'h00;
  localparam logic [4:0] STATUS_RST = 5'h18;
  localparam logic [7:0] WDT_CLEAR  = 8'h00;
  localparam logic [0:0] CTRL_RST   = 1'h0;

  // Operations started by a command write
  typedef enum logic [2:0] {
    OP_NOP   = 3'b000,
    OP_ROTR  = 3'b001,
    OP_LSUB  = 3'b010,
    OP_RSUB  = 3'b011,
    OP_RSUBB = 3'b100,
    OP_SWAP  = 3'b101,
    OP_SLEEP = 3'b110
  } rssx_op_e;
endpackage

// *** rtl/rssx_alu_if.sv ***
`timescale 1ns/10ps
interface rssx_alu_if;
  rssx_pkg::rssx_op_e op;
  logic [7:0]         operand;
  logic [7:0]         acc;
  logic [7:0]         lit;
  logic               c_in;
  logic [7:0]         result;
  logic               c_out;
  logic               dc_out;
  logic               z_out;

  modport core (output op, operand, acc, lit, c_in,
                input  result, c_out, dc_out, z_out);
  modport alu  (input  op, operand, acc, lit, c_in,
                output result, c_out, dc_out, z_out);
endinterface

// *** rtl/rssx_alu.sv ***
`timescale 1ns/10ps
module rssx_alu (
  rssx_alu_if.alu a
);
  wire       is_lsub;
  wire       is_bsub;
  wire [7:0] minuend;
  wire       cin;
  wire [8:0] sub_full;
  wire [4:0] sub_low;
  wire       is_sub;

  // Two's complement subtract: minuend + ~acc + carry-in
  assign is_lsub  = (a.op == rssx_pkg::OP_LSUB);
  assign is_bsub  = (a.op == rssx_pkg::OP_RSUBB);
  assign is_sub   = is_lsub | is_bsub | (a.op == rssx_pkg::OP_RSUB);
  assign minuend  = is_lsub ? a.lit : a.operand;
  assign cin      = is_bsub ? a.c_in : 1'b1;
  assign sub_full = {1'b0, minuend} + {1'b0, ~a.acc} + {8'h00, cin};
  assign sub_low  = {1'b0, minuend[3:0]} + {1'b0, ~a.acc[3:0]}
                  + {4'h0, cin};

  // Result selection per operation
  assign a.result = (a.op == rssx_pkg::OP_ROTR) ?
                      {a.c_in, a.operand[7:1]} :
                    (a.op == rssx_pkg::OP_SWAP) ?
                      {a.operand[3:0], a.operand[7:4]} :
                    is_sub ? sub_full[7:0] : a.acc;

  // Carry is inverted borrow; half carry likewise on the low nibble
  assign a.c_out  = (a.op == rssx_pkg::OP_ROTR) ? a.operand[0] :
                    is_sub ? sub_full[8] : a.c_in;
  assign a.dc_out = sub_low[4];
  assign a.z_out  = (sub_full[7:0] == 8'h00);
endmodule

// *** rtl/rssx_file.sv ***
`timescale 1ns/10ps
module rssx_file #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic          pclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr_a,
  output logic      [7:0]    rdata_a,
  input  wire logic [AW-1:0] raddr_b,
  output logic      [7:0]    rdata_b
);
  logic [7:0] mem [DEPTH];

  initial begin
    if (DEPTH != (1 << AW)) begin
      $error("rssx_file: DEPTH must equal 2**AW");
    end
  end

  // Data memory write; contents are undefined after power-up
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Two asynchronous read ports: operand fetch and bus readback
  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
endmodule

// *** rtl/rssx_exec.sv ***
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module rssx_exec #(
  parameter int DEPTH  = 128,
  parameter int PRE_W  = 8,
  parameter int WDT_W  = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH != 128 || WDT_W != 8 || PRE_W < 1 || PRE_W > 16) begin
      $error("rssx_exec: unsupported parameter values");
    end
  end

  // Word decode of a bus address
  function automatic logic is_file(input logic [11:0] ad);
    is_file = (ad >= rssx_pkg::OFF_FILE) &&
              (ad < rssx_pkg::OFF_FILE + rssx_pkg::FILE_SPAN) &&
              (ad[1:0] == 2'b00);
  endfunction

  function automatic logic is_mapped(input logic [11:0] ad);
    is_mapped = is_file(ad) || (ad == rssx_pkg::OFF_CMD) ||
                (ad == rssx_pkg::OFF_ACC) || (ad == rssx_pkg::OFF_STATUS) ||
                (ad == rssx_pkg::OFF_WDT) || (ad == rssx_pkg::OFF_CTRL);
  endfunction

  rssx_alu_if alu_bus ();

  logic [7:0]       acc_r;
  logic [7:0]       acc_nxt;
  logic [4:0]       status_r;
  logic [4:0]       status_nxt;
  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic [WDT_W-1:0] wdt_r;
  logic [WDT_W-1:0] wdt_nxt;
  logic [0:0]       ctrl_r;
  logic [31:0]      prdata_nxt;
  logic             pready_nxt;
  logic             pslverr_nxt;

  wire              access;
  wire              fire;
  wire              wr_fire;
  wire              cmd_fire;
  wire              acc_wr;
  wire              st_wr;
  wire              ctrl_wr;
  wire              file_bus_wr;
  wire [AW-1:0]     bus_idx;
  wire [7:0]        bus_rdata;
  wire [7:0]        opnd;
  rssx_pkg::rssx_op_e op_w;
  wire              dest_w;
  wire [AW-1:0]     fa_w;
  wire              has_dest;
  wire              is_sub;
  wire              to_acc;
  wire              to_file;
  wire              is_sleep;
  wire              pre_wrap;
  wire              wdt_wrap;
  wire              file_we;
  wire [AW-1:0]     file_wa;
  wire [7:0]        file_wd;

  // Bus phase decode; one wait state per transfer
  assign access      = psel & penable;
  assign fire        = access & pready;
  assign wr_fire     = fire & pwrite;
  assign cmd_fire    = wr_fire & (paddr == rssx_pkg::OFF_CMD);
  assign acc_wr      = wr_fire & (paddr == rssx_pkg::OFF_ACC);
  assign st_wr       = wr_fire & (paddr == rssx_pkg::OFF_STATUS);
  assign ctrl_wr     = wr_fire & (paddr == rssx_pkg::OFF_CTRL);
  assign file_bus_wr = wr_fire & is_file(paddr);
  assign bus_idx     = paddr[AW+1:2];

  // Command word fields
  assign op_w   = rssx_pkg::rssx_op_e'(pwdata[rssx_pkg::CMD_OP_LSB +: 3]);
  assign dest_w = pwdata[rssx_pkg::CMD_DEST_BIT];
  assign fa_w   = pwdata[rssx_pkg::CMD_FA_LSB +: AW];

  // Operation classes
  assign has_dest = (op_w == rssx_pkg::OP_ROTR) ||
                    (op_w == rssx_pkg::OP_RSUB) ||
                    (op_w == rssx_pkg::OP_RSUBB) ||
                    (op_w == rssx_pkg::OP_SWAP);
  assign is_sub   = (op_w == rssx_pkg::OP_LSUB) ||
                    (op_w == rssx_pkg::OP_RSUB) ||
                    (op_w == rssx_pkg::OP_RSUBB);
  assign is_sleep = cmd_fire & (op_w == rssx_pkg::OP_SLEEP);

  // Result routing by destination select
  assign to_acc  = cmd_fire & ((op_w == rssx_pkg::OP_LSUB) ||
                               (has_dest & ~dest_w));
  assign to_file = cmd_fire & has_dest & dest_w;

  // Operands into the datapath
  assign alu_bus.op      = op_w;
  assign alu_bus.operand = opnd;
  assign alu_bus.acc     = acc_r;
  assign alu_bus.lit     = pwdata[rssx_pkg::CMD_LIT_LSB +: 8];
  assign alu_bus.c_in    = status_r[rssx_pkg::ST_C];

  rssx_alu u_alu (
    .a (alu_bus.alu)
  );

  // Data memory write: bus writes or results sent back
  assign file_we = file_bus_wr | to_file;
  assign file_wa = to_file ? fa_w : bus_idx;
  assign file_wd = to_file ? alu_bus.result : pwdata[7:0];

  rssx_file #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_file (
    .pclk    (pclk),
    .we      (file_we),
    .waddr   (file_wa),
    .wdata   (file_wd),
    .raddr_a (fa_w),
    .rdata_a (opnd),
    .raddr_b (bus_idx),
    .rdata_b (bus_rdata)
  );

  // Accumulator next value
  assign acc_nxt = acc_wr ? pwdata[7:0] :
                   to_acc ? alu_bus.result : acc_r;

  // Watchdog prescaler and counter; sleep clears both
  assign pre_wrap = ctrl_r[rssx_pkg::CTRL_WDT_EN] & (&pre_r);
  assign wdt_wrap = pre_wrap & (&wdt_r);
  assign pre_nxt  = is_sleep ? '0 :
                    ctrl_r[rssx_pkg::CTRL_WDT_EN] ?
                      pre_r + PRE_W'(1) : pre_r;
  assign wdt_nxt  = is_sleep ? rssx_pkg::WDT_CLEAR :
                    pre_wrap ? wdt_r + WDT_W'(1) : wdt_r;

  // Status flags; hardware updates win over a software write
  always_comb begin
    status_nxt = st_wr ? pwdata[4:0] : status_r;
    if (wdt_wrap) begin
      status_nxt[rssx_pkg::ST_TO] = 1'b0;
    end
    if (cmd_fire && (op_w == rssx_pkg::OP_ROTR || is_sub)) begin
      status_nxt[rssx_pkg::ST_C] = alu_bus.c_out;
    end
    if (cmd_fire && is_sub) begin
      status_nxt[rssx_pkg::ST_DC] = alu_bus.dc_out;
      status_nxt[rssx_pkg::ST_Z]  = alu_bus.z_out;
    end
    if (is_sleep) begin
      status_nxt[rssx_pkg::ST_PD] = 1'b0;
      status_nxt[rssx_pkg::ST_TO] = 1'b1;
    end
  end

  // Read data and answer for the access phase
  assign pready_nxt  = access & ~pready;
  assign pslverr_nxt = access & ~pready & ~is_mapped(paddr);
  assign prdata_nxt  =
    (!access || pready || pwrite)            ? 32'h0000_0000 :
    is_file(paddr)                           ? {24'h00_0000, bus_rdata} :
    (paddr == rssx_pkg::OFF_ACC)             ? {24'h00_0000, acc_r} :
    (paddr == rssx_pkg::OFF_STATUS)          ? {27'h000_0000, status_r} :
    (paddr == rssx_pkg::OFF_WDT)             ?
      {16'h0000, 8'(pre_r), wdt_r} :
    (paddr == rssx_pkg::OFF_CTRL)            ? {31'h0000_0000, ctrl_r} :
    32'h0000_0000;

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
      prdata  <= prdata_nxt;
    end
  end

  // Core state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r    <= rssx_pkg::ACC_RST;
      status_r <= rssx_pkg::STATUS_RST;
      pre_r    <= '0;
      wdt_r    <= rssx_pkg::WDT_CLEAR;
      ctrl_r   <= rssx_pkg::CTRL_RST;
    end else begin
      acc_r    <= acc_nxt;
      status_r <= status_nxt;
      pre_r    <= pre_nxt;
      wdt_r    <= wdt_nxt;
      ctrl_r   <= ctrl_wr ? pwdata[0:0] : ctrl_r;
    end
  end
endmodule

// *** dv/rssx_exec_asserts.sv ***
`timescale 1ns/10ps
module rssx_exec_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed transfers and a flag for a last write that was a sleep
  wire  rd_ok = psel && penable && pready && !pwrite;
  wire  wr_ok = psel && penable && pready && pwrite;
  logic slp_r;
  logic slp_nxt;
  assign slp_nxt = wr_ok ? (paddr == rssx_pkg::OFF_CMD &&
                   pwdata[2:0] == rssx_pkg::OP_SLEEP) : slp_r;
  // Flag register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) slp_r <= 1'h0;
    else slp_r <= slp_nxt;
  end
  // Setup phase, then exactly one wait state
  sequence setup_s; psel && !penable; endsequence
  sequence wait_s; !pready ##1 pready && penable; endsequence
  ready_timing_a: assert property (setup_s |=> wait_s)
    else $error("pready not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside completion");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero while idle");
  cmd_read_a: assert property (rd_ok && paddr == rssx_pkg::OFF_CMD
    |-> prdata == 32'h0) else $error("command read not zero");
  upper_zero_a: assert property (rd_ok && paddr != rssx_pkg::OFF_WDT
    |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  sleep_flags_a: assert property (
    rd_ok && slp_r && paddr == rssx_pkg::OFF_STATUS |-> prdata[4:3] == 2'h2)
    else $error("sleep status flags wrong");
  sleep_wdt_a: assert property (
    rd_ok && slp_r && paddr == rssx_pkg::OFF_WDT |-> prdata[7:0] == 8'h0)
    else $error("watchdog count not cleared");
endmodule

bind rssx_exec rssx_exec_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

// *** dv/tb_rssx_exec.sv ***
`timescale 1ns/10ps
module tb_rssx_exec;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic [31:0] rv;
  logic [31:0] rw;
  logic        er;
  logic [7:0]  acc_m;
  logic [4:0]  st_m;
  logic [7:0]  f_m;
  int          error_cnt = 0;
  int          checked = 0;
  int          cyc = 0;

  rssx_exec #(.PRE_W(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // Clock
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    // Answer is taken at the rising edge where pready is seen high
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
  endtask

  // Expected accumulator, flags and register after one command
  function automatic void model(input logic [2:0] op, input logic d,
                                input logic [7:0] k);
    logic [8:0] df;
    logic [4:0] dn;
    logic [7:0] f;
    logic [7:0] r;
    logic       b;
    f  = (op == 3'h2) ? k : f_m;
    b  = (op == 3'h4) ? ~st_m[0] : 1'h0;
    df = {1'h0, f} - {1'h0, acc_m} - {8'h0, b};
    dn = {1'h0, f[3:0]} - {1'h0, acc_m[3:0]} - {4'h0, b};
    r  = (op == 3'h5) ? {f[3:0], f[7:4]} : df[7:0];
    if (op == 3'h1) begin
      r = {st_m[0], f[7:1]};
      st_m[0] = f[0];
    end
    if (op > 3'h1 && op < 3'h5)
      st_m[2:0] = {r == 8'h0, ~dn[4], ~df[8]};
    if (!d || op == 3'h2) acc_m = r;
    else f_m = r;
  endfunction

  // Load operands, run a command, read everything back
  task automatic run(input logic [2:0] op, input logic d,
    input logic [6:0] fa, input logic [7:0] k, input logic [7:0] a,
    input logic [4:0] s, input logic [7:0] f);
    logic [11:0] fad;
    fad   = rssx_pkg::OFF_FILE + {3'h0, fa, 2'h0};
    acc_m = a;
    st_m  = s;
    f_m   = f;
    apb(1'h1, rssx_pkg::OFF_ACC, {24'h0, a});
    apb(1'h1, rssx_pkg::OFF_STATUS, {27'h0, s});
    apb(1'h1, fad, {24'h0, f});
    apb(1'h1, rssx_pkg::OFF_CMD, {8'h0, k, 5'h0, fa, d, op});
    model(op, d, k);
    apb(1'h0, rssx_pkg::OFF_ACC, 32'h0);
    chk(rd, {24'h0, acc_m});
    apb(1'h0, rssx_pkg::OFF_STATUS, 32'h0);
    chk(rd, {27'h0, st_m});
    apb(1'h0, fad, 32'h0);
    chk(rd, {24'h0, f_m});
  endtask

  // Main sequence
  initial begin
    presetn = 1'h0;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 12'h0;
    pwdata  = 32'h0;
    rv      = $urandom(32'hFDC6);
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, rssx_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h18);
    // Equal operands, nibble borrow, borrow in, carry in, flags kept
    run(3'h2, 1'h1, 7'h00, 8'h35, 8'h35, 5'h00, 8'h00);
    run(3'h3, 1'h1, 7'h7F, 8'h00, 8'h0F, 5'h18, 8'h10);
    run(3'h4, 1'h0, 7'h05, 8'h00, 8'h10, 5'h00, 8'h10);
    run(3'h1, 1'h1, 7'h09, 8'h00, 8'h00, 5'h01, 8'h01);
    run(3'h5, 1'h0, 7'h03, 8'h00, 8'h00, 5'h1F, 8'hA5);
    for (int i = 0; i < 300; i++) begin
      rv = $urandom;
      rw = $urandom;
      run(3'($urandom_range(5, 1)), rv[0], rv[7:1], rv[15:8], rv[23:16],
          rw[4:0], rw[15:8]);
    end
    // Unmapped place and the write-only command word
    apb(1'h0, 12'h014, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'h0, rssx_pkg::OFF_CMD, 32'h0);
    chk(rd, 32'h0);
    // Watchdog runs a while, then a sleep clears it
    apb(1'h1, rssx_pkg::OFF_CTRL, 32'h1);
    psel    <= 1'h0;
    penable <= 1'h0;
    repeat (300) @(posedge pclk);
    apb(1'h0, rssx_pkg::OFF_WDT, 32'h0);
    chk({31'h0, rd[7:0] != 8'h0}, 32'h1);
    apb(1'h1, rssx_pkg::OFF_STATUS, 32'h08);
    apb(1'h1, rssx_pkg::OFF_CMD, {29'h0, rssx_pkg::OP_SLEEP});
    apb(1'h0, rssx_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h10);
    apb(1'h0, rssx_pkg::OFF_WDT, 32'h0);
    chk({24'h0, rd[7:0]}, 32'h0);
    chk({31'h0, rd[15:8] < 8'h0C}, 32'h1);
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
    report_and_stop();
  end
endmodule
